// File: rtl/mpc_master_page.sv
// Purpose: master-page power, clock and frame-reference control registers
// Assumes: serial port pins and power-down pin synchronous to clock_in
// Notes: master registers answer only while the page field holds the master code
//
// Behaviour
// R1: Host sets pin override before global power-down
// R2: Global power-down bit forces full power-down
// R3: Pin override makes power-down pin ignored
// R4: Mask select chooses first or second mask
// R5: Masked power-down powers down selected mask blocks
// R6: Host sets bias enable with current boost
// R7: Host sets current boost with bias enable
// R8: Host writes ones to bits 7:5, zeros elsewhere
// R9: Clock divider bit selects divide by four/two
// R10: Host programs divide by two
// R11: Frame-reference ignore bit blocks the input
// R12: Page field selects page; master is 80h
// R13: Masks held at 20h/21h and 23h/24h
// R14: Power-down is OR of pin, global, mask
module mpc_master_page
   import mpc_pkg::*;
#(
   parameter int MASK_W = 12
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic sen_n_in,
   input wire logic sclk_in,
   input wire logic sdi_in,
   input wire logic pdn_pin_in,
   input wire logic sysref_in,
   output logic sdout_out,
   output logic full_powerdown_out,
   output logic [MASK_W-1:0] block_powerdown_out,
   output logic sample_enable_out,
   output logic frame_ref_out,
   output logic buffer_current_boost_out,
   output logic input_buffer_bias_enable_out,
   output logic [2:0] required_ones_out
);
   typedef struct packed {
      logic [7:0] register_page_field;
      logic global_powerdown;
      logic pin_override;
      logic mask_select;
      logic [2:0] required_ones;
      logic buffer_current_boost;
      logic clk_div_two;
      logic frame_ref_ignore;
      logic masked_powerdown_enable;
      logic input_buffer_bias_enable;
      logic [MASK_W-1:0] mask1;
      logic [MASK_W-1:0] mask2;
      logic [1:0] div_cnt;
      logic sample_en;
      logic full_pd;
      logic [MASK_W-1:0] block_pd;
      logic frame_ref;
   } mpc_regs_s;

   mpc_reg_if bus ();

   mpc_regs_s r_reg;
   mpc_regs_s r_next;
   logic master_sel;
   logic [7:0] rdata;
   logic [1:0] div_last;
   logic [MASK_W-1:0] sel_mask;
   logic pin_pd;

   mpc_serial_engine u_engine (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .sen_n_in(sen_n_in),
      .sclk_in(sclk_in),
      .sdi_in(sdi_in),
      .sdout_out(sdout_out),
      .bus(bus.engine)
   );

   assign master_sel = (r_reg.register_page_field == MPC_PAGE_MASTER); // R12

   // Read decode; reserved and write-only bits read as zero
   always_comb begin
      rdata = MPC_RESET_BYTE;
      if (bus.addr == MPC_ADDR_PAGE) begin
         rdata = r_reg.register_page_field; // R12
      end else if (master_sel) begin
         case (bus.addr)
            MPC_ADDR_MASK1_HI: rdata = r_reg.mask1[MASK_W-1:4]; // R13
            MPC_ADDR_MASK1_LO: rdata = {r_reg.mask1[3:0], 4'h0};
            MPC_ADDR_MASK2_HI: rdata = r_reg.mask2[MASK_W-1:4];
            MPC_ADDR_MASK2_LO: rdata = {r_reg.mask2[3:0], 4'h0};
            MPC_ADDR_POWER: begin
               rdata[MPC_POS_GLOBAL_PD] = r_reg.global_powerdown;
               rdata[MPC_POS_PIN_OVERRIDE] = r_reg.pin_override;
               rdata[MPC_POS_MASK_SELECT] = r_reg.mask_select;
            end
            MPC_ADDR_REQ_ONES: begin
               rdata[MPC_POS_REQ_ONES_LO +: 3] = r_reg.required_ones;
            end
            MPC_ADDR_BOOST: begin
               rdata[MPC_POS_BOOST] = r_reg.buffer_current_boost;
            end
            MPC_ADDR_CLK_FRAME: begin
               rdata[MPC_POS_CLK_DIV] = r_reg.clk_div_two;
               rdata[MPC_POS_FRAME_IGNORE] = r_reg.frame_ref_ignore;
            end
            MPC_ADDR_MASKED_PD: begin
               rdata[MPC_POS_MASKED_PD] = r_reg.masked_powerdown_enable;
            end
            MPC_ADDR_BIAS: begin
               rdata[MPC_POS_BIAS] = r_reg.input_buffer_bias_enable;
            end
            default: rdata = MPC_RESET_BYTE;
         endcase
      end
   end

   assign bus.rdata = rdata;

   always_comb begin
      r_next = r_reg;
      if (bus.wr_stb) begin
         if (bus.addr == MPC_ADDR_PAGE) begin
            r_next.register_page_field = bus.wdata; // R12
         end else if (master_sel) begin
            case (bus.addr)
               MPC_ADDR_MASK1_HI: r_next.mask1[MASK_W-1:4] = bus.wdata; // R13
               MPC_ADDR_MASK1_LO: r_next.mask1[3:0] = bus.wdata[MPC_POS_MASK_LO_HI:MPC_POS_MASK_LO_LO]; // R13
               MPC_ADDR_MASK2_HI: r_next.mask2[MASK_W-1:4] = bus.wdata; // R13
               MPC_ADDR_MASK2_LO: r_next.mask2[3:0] = bus.wdata[MPC_POS_MASK_LO_HI:MPC_POS_MASK_LO_LO]; // R13
               MPC_ADDR_POWER: begin
                  // Global bit only moves while the override already stands
                  if (r_reg.pin_override) begin
                     r_next.global_powerdown = bus.wdata[MPC_POS_GLOBAL_PD]; // R1
                  end
                  r_next.pin_override = bus.wdata[MPC_POS_PIN_OVERRIDE];
                  r_next.mask_select = bus.wdata[MPC_POS_MASK_SELECT];
               end
               MPC_ADDR_REQ_ONES: begin
                  r_next.required_ones = bus.wdata[MPC_POS_REQ_ONES_LO +: 3]; // R8
               end
               MPC_ADDR_BOOST: begin
                  r_next.buffer_current_boost = bus.wdata[MPC_POS_BOOST];
               end
               MPC_ADDR_CLK_FRAME: begin
                  r_next.clk_div_two = bus.wdata[MPC_POS_CLK_DIV];
                  r_next.frame_ref_ignore = bus.wdata[MPC_POS_FRAME_IGNORE];
               end
               MPC_ADDR_MASKED_PD: begin
                  r_next.masked_powerdown_enable = bus.wdata[MPC_POS_MASKED_PD];
               end
               MPC_ADDR_BIAS: begin
                  r_next.input_buffer_bias_enable = bus.wdata[MPC_POS_BIAS];
               end
               default: r_next.register_page_field = r_reg.register_page_field;
            endcase
         end
      end

      // Input clock divider: one-cycle enable every 4 or 2 clocks
      div_last = r_reg.clk_div_two ? MPC_DIV2_LAST : MPC_DIV4_LAST; // R9
      if (r_reg.div_cnt >= div_last) begin
         r_next.div_cnt = 2'h0;
         r_next.sample_en = 1'b1;
      end else begin
         r_next.div_cnt = r_reg.div_cnt + 2'h1;
         r_next.sample_en = 1'b0;
      end

      sel_mask = r_reg.mask_select ? r_reg.mask2 : r_reg.mask1; // R4
      pin_pd = pdn_pin_in & ~r_reg.pin_override; // R3
      r_next.full_pd = pin_pd | r_reg.global_powerdown; // R2 R14
      if (r_next.full_pd) begin
         r_next.block_pd = '1; // R14
      end else if (r_reg.masked_powerdown_enable) begin
         r_next.block_pd = sel_mask; // R5
      end else begin
         r_next.block_pd = '0;
      end
      r_next.frame_ref = sysref_in & ~r_reg.frame_ref_ignore; // R11
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign full_powerdown_out = r_reg.full_pd;
   assign block_powerdown_out = r_reg.block_pd;
   assign sample_enable_out = r_reg.sample_en;
   assign frame_ref_out = r_reg.frame_ref;
   assign buffer_current_boost_out = r_reg.buffer_current_boost; // R6
   assign input_buffer_bias_enable_out = r_reg.input_buffer_bias_enable; // R7
   assign required_ones_out = r_reg.required_ones;
endmodule

// File: rtl/mpc_pkg.sv
// Purpose: constants and types shared by the master-page power control block
// Assumes: 8-bit registers, 12-bit register address in a 24-bit serial frame
// Notes: frame is read flag, page-mode flag, two zero bits, address, data
package mpc_pkg;
   localparam int MPC_ADDR_W = 12;
   localparam int MPC_DATA_W = 8;
   localparam int MPC_FRAME_BITS = 24;
   localparam logic [4:0] MPC_HDR_BITS = 5'h10;
   localparam logic [4:0] MPC_ALL_BITS = 5'h18;
   localparam int MPC_RW_POS = 15;

   localparam logic [11:0] MPC_ADDR_PAGE = 12'h011;
   localparam logic [11:0] MPC_ADDR_MASK1_HI = 12'h020;
   localparam logic [11:0] MPC_ADDR_MASK1_LO = 12'h021;
   localparam logic [11:0] MPC_ADDR_MASK2_HI = 12'h023;
   localparam logic [11:0] MPC_ADDR_MASK2_LO = 12'h024;
   localparam logic [11:0] MPC_ADDR_POWER = 12'h026;
   localparam logic [11:0] MPC_ADDR_REQ_ONES = 12'h039;
   localparam logic [11:0] MPC_ADDR_BOOST = 12'h03A;
   localparam logic [11:0] MPC_ADDR_CLK_FRAME = 12'h053;
   localparam logic [11:0] MPC_ADDR_MASKED_PD = 12'h055;
   localparam logic [11:0] MPC_ADDR_BIAS = 12'h056;

   localparam logic [7:0] MPC_PAGE_MASTER = 8'h80;

   localparam int MPC_POS_GLOBAL_PD = 7;
   localparam int MPC_POS_PIN_OVERRIDE = 6;
   localparam int MPC_POS_MASK_SELECT = 5;
   localparam int MPC_POS_REQ_ONES_LO = 5;
   localparam int MPC_POS_BOOST = 6;
   localparam int MPC_POS_CLK_DIV = 7;
   localparam int MPC_POS_FRAME_IGNORE = 6;
   localparam int MPC_POS_MASKED_PD = 4;
   localparam int MPC_POS_BIAS = 3;
   localparam int MPC_POS_MASK_LO_HI = 7;
   localparam int MPC_POS_MASK_LO_LO = 4;

   localparam logic [7:0] MPC_RESET_BYTE = 8'h00;
   localparam logic [11:0] MPC_MASK_RESET = 12'h000;
   localparam logic [1:0] MPC_DIV4_LAST = 2'h3;
   localparam logic [1:0] MPC_DIV2_LAST = 2'h1;

   typedef enum logic [3:0] {
      MPC_ST_IDLE = 4'b0001,
      MPC_ST_HDR = 4'b0010,
      MPC_ST_DATA = 4'b0100,
      MPC_ST_WAIT = 4'b1000
   } mpc_state_e;
endpackage

// File: rtl/mpc_reg_if.sv
// Purpose: carries register requests from the serial engine to the register file
// Assumes: one clock; strobes are single-cycle pulses
// Notes: read data is answered combinationally in the request cycle
interface mpc_reg_if;
   logic wr_stb;
   logic rd_req;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport engine (output wr_stb, output rd_req, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input rd_req, input addr, input wdata, output rdata);
endinterface

// File: rtl/mpc_serial_engine.sv
// Purpose: serial programming port engine, pins oversampled by the system clock
// Assumes: serial clock well below half the system clock, pins synchronous
// Notes: data in on serial clock rise, read data out on fall, MSB first
module mpc_serial_engine
   import mpc_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic sen_n_in,
   input wire logic sclk_in,
   input wire logic sdi_in,
   output logic sdout_out,
   mpc_reg_if.engine bus
);
   typedef struct packed {
      mpc_state_e state;
      logic sclk_prev;
      logic [4:0] cnt;
      logic [23:0] shreg;
      logic load;
      logic [7:0] out_sh;
      logic sdout;
      logic wr_stb;
      logic rd_req;
      logic [11:0] addr;
      logic [7:0] wdata;
   } mpc_eng_s;

   mpc_eng_s r_reg;
   mpc_eng_s r_next;
   logic rise;
   logic fall;

   always_comb begin
      r_next = r_reg;
      rise = sclk_in & ~r_reg.sclk_prev;
      fall = ~sclk_in & r_reg.sclk_prev;
      r_next.sclk_prev = sclk_in;
      r_next.wr_stb = 1'b0;
      r_next.rd_req = 1'b0;
      r_next.load = 1'b0;
      if (r_reg.load) begin
         r_next.out_sh = bus.rdata;
         r_next.sdout = bus.rdata[7];
      end
      case (r_reg.state)
         MPC_ST_IDLE: begin
            r_next.cnt = 5'h00;
            r_next.sdout = 1'b0;
            if (!sen_n_in) begin
               r_next.state = MPC_ST_HDR;
            end
         end
         MPC_ST_HDR: begin
            if (sen_n_in) begin
               r_next.state = MPC_ST_IDLE;
            end else if (rise) begin
               r_next.shreg = {r_reg.shreg[22:0], sdi_in};
               r_next.cnt = r_reg.cnt + 5'h01;
               if (r_reg.cnt + 5'h01 == MPC_HDR_BITS) begin
                  r_next.addr = r_next.shreg[11:0];
                  r_next.rd_req = r_next.shreg[MPC_RW_POS];
                  r_next.load = r_next.shreg[MPC_RW_POS];
                  r_next.state = MPC_ST_DATA;
               end
            end
         end
         MPC_ST_DATA: begin
            if (sen_n_in) begin
               r_next.state = MPC_ST_IDLE;
            end else if (rise) begin
               r_next.shreg = {r_reg.shreg[22:0], sdi_in};
               r_next.cnt = r_reg.cnt + 5'h01;
               if (r_reg.cnt + 5'h01 == MPC_ALL_BITS) begin
                  r_next.wdata = r_next.shreg[7:0];
                  r_next.wr_stb = ~r_next.shreg[MPC_RW_POS + 8];
                  r_next.state = MPC_ST_WAIT;
               end
            end else if (fall && !r_reg.load) begin
               r_next.out_sh = {r_reg.out_sh[6:0], 1'b0};
               r_next.sdout = r_reg.out_sh[6];
            end
         end
         MPC_ST_WAIT: begin
            // Extra clocks inside the frame are ignored
            if (sen_n_in) begin
               r_next.state = MPC_ST_IDLE;
            end
         end
         default: begin
            r_next.state = MPC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         r_reg <= '{state: MPC_ST_IDLE, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign sdout_out = r_reg.sdout;
   assign bus.wr_stb = r_reg.wr_stb;
   assign bus.rd_req = r_reg.rd_req;
   assign bus.addr = r_reg.addr;
   assign bus.wdata = r_reg.wdata;
endmodule

// File: tb/mpc_master_page_props.sv
// Purpose: port checks of the master-page control block
// Assumes: one clock, reset async active high
// Notes: bound from the bench top
module mpc_master_page_props
   import mpc_pkg::*;
#(
   parameter int MASK_W = 12
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic sen_n_in,
   input wire logic sysref_in,
   input wire logic pdn_pin_in,
   input wire logic sdout_out,
   input wire logic full_powerdown_out,
   input wire logic [MASK_W-1:0] block_powerdown_out,
   input wire logic sample_enable_out,
   input wire logic frame_ref_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   full_pd_all_a: assert property (full_powerdown_out |-> &block_powerdown_out)
      else $error("block power-down not all ones");
   frame_ref_src_a: assert property (frame_ref_out |-> $past(sysref_in))
      else $error("frame reference without input");
   frame_ref_hold_a: assert property (frame_ref_out && sysref_in && sen_n_in && $past(sen_n_in, 3) |=> frame_ref_out)
      else $error("frame reference dropped");
   pulse_gap_a: assert property (sample_enable_out |=> !sample_enable_out)
      else $error("sample enable pulses adjacent");
   pulse_period_a: assert property (sample_enable_out |=> ##[0:3] sample_enable_out)
      else $error("sample enable period too long");
   first_pulse_a: assert property ($fell(rst_in) |-> !sample_enable_out [*3] ##[1:2] sample_enable_out)
      else $error("first sample enable misplaced");
   pin_after_reset_a: assert property ($fell(rst_in) |=> full_powerdown_out == $past(pdn_pin_in))
      else $error("power-down not following pin");
   sdout_quiet_a: assert property (sen_n_in [*3] |-> !sdout_out)
      else $error("serial output active outside frame");
   cover property ($rose(full_powerdown_out));
   cover property (sample_enable_out ##2 sample_enable_out);
   cover property ($rose(frame_ref_out));
endmodule

// File: tb/mpc_host_model.sv
// Purpose: host driving the serial programming port
// Assumes: sclk high and low three clocks each
// Notes: read bit taken just before sclk is lowered
module mpc_host_model (
   input wire logic clock_in,
   input wire logic sdout_in,
   output logic sen_n_out,
   output logic sclk_out,
   output logic sdi_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sen_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
   end
   task automatic xfer(input logic [23:0] frame, output logic [7:0] rdat);
      rdat = 8'h00;
      @(posedge clock_in) sen_n_out <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge clock_in) sdi_out <= frame[i];
         repeat (2) @(posedge clock_in);
         sclk_out <= 1'b1;
         repeat (3) @(posedge clock_in);
         // Engine shifts on each fall, so take the bit before lowering sclk
         if (i >= 1 && i <= 8) rdat[i - 1] = sdout_in;
         sclk_out <= 1'b0;
      end
      repeat (3) @(posedge clock_in);
      sen_n_out <= 1'b1;
      // Released data line shows no stale bit
      sdi_out <= ~sdi_out;
   endtask
endmodule

// File: tb/mpc_master_page_test.sv
// Purpose: self-checking bench of the master-page control block
// Assumes: 25 MHz clock, host model on the serial port
// Notes: random mask contents and frame reference from an LFSR
module mpc_master_page_test;
   import mpc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_in, rst_in, pdn_pin_in, sysref_in, sen_n, sclk, sdi, sdout, full_pd, boost, bias, sample_en, frame_ref;
   logic [11:0] block_pd;
   logic [2:0] req_ones;
   logic [15:0] lfsr_reg, r1, r2;
   logic [7:0] junk;
   logic [11:0] regs [7] = '{MPC_ADDR_POWER, MPC_ADDR_REQ_ONES, MPC_ADDR_BOOST, MPC_ADDR_CLK_FRAME,
                             MPC_ADDR_MASKED_PD, MPC_ADDR_BIAS, 12'h030};
   int mismatches = 0;
   int compares = 0;
   mpc_host_model i_mpc_host_model (.clock_in(clock_in), .sdout_in(sdout), .sen_n_out(sen_n), .sclk_out(sclk),
      .sdi_out(sdi));
   mpc_master_page #(.MASK_W(12)) i_mpc_master_page (.clock_in(clock_in), .rst_in(rst_in), .sen_n_in(sen_n),
      .sclk_in(sclk), .sdi_in(sdi), .pdn_pin_in(pdn_pin_in), .sysref_in(sysref_in), .sdout_out(sdout),
      .full_powerdown_out(full_pd), .block_powerdown_out(block_pd), .sample_enable_out(sample_en),
      .frame_ref_out(frame_ref), .buffer_current_boost_out(boost), .input_buffer_bias_enable_out(bias),
      .required_ones_out(req_ones));
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [11:0] mask_exp(input logic [7:0] hi, input logic [7:0] lo);
      return {hi, lo[7:4]};
   endfunction
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      i_mpc_host_model.xfer({4'h0, a, d}, junk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_mpc_host_model.xfer({4'h8, a, 8'h00}, d);
      check({4'h0, d}, {4'h0, e});
   endtask
   task automatic count_pulses(input int exp);
      int cnt;
      cnt = 0;
      repeat (40) begin
         @(posedge clock_in);
         if (sample_en === 1'b1) cnt++;
         sysref_in <= lfsr_reg[0];
         lfsr_reg = lfsr_next(lfsr_reg);
      end
      check(12'(cnt), 12'(exp));
   endtask
   task automatic print_verdict();
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   initial begin
      repeat (30000) @(posedge clock_in);
      mismatches++;
      print_verdict();
   end
   initial begin
      rst_in = 1'b1;
      pdn_pin_in = 1'b0;
      sysref_in = 1'b0;
      lfsr_reg = 16'h5D12;
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      // First pulse lands four edges after release
      count_pulses(9);
      @(posedge clock_in);
      sysref_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      check({full_pd, boost, bias, req_ones, frame_ref}, 12'h000);
      rd(MPC_ADDR_POWER, 8'h00);
      wr(MPC_ADDR_POWER, 8'h40);
      wr(MPC_ADDR_PAGE, MPC_PAGE_MASTER);
      rd(MPC_ADDR_PAGE, MPC_PAGE_MASTER);
      foreach (regs[i]) rd(regs[i], 8'h00);
      pdn_pin_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      check({11'h0, full_pd}, 12'h001);
      wr(MPC_ADDR_POWER, 8'h80);
      rd(MPC_ADDR_POWER, 8'h00);
      wr(MPC_ADDR_POWER, 8'hC0);
      rd(MPC_ADDR_POWER, 8'h40);
      check({11'h0, full_pd}, 12'h000);
      wr(MPC_ADDR_POWER, 8'hC0);
      rd(MPC_ADDR_POWER, 8'hC0);
      check({full_pd, block_pd[10:0]}, 12'hFFF);
      pdn_pin_in <= 1'b0;
      wr(MPC_ADDR_POWER, 8'h40);
      check({11'h0, full_pd}, 12'h000);
      wr(MPC_ADDR_MASKED_PD, 8'h10);
      for (int k = 0; k < 3; k++) begin
         r1 = lfsr_reg;
         r2 = lfsr_next(r1);
         lfsr_reg = lfsr_next(r2);
         wr(MPC_ADDR_MASK1_HI, r1[15:8]);
         wr(MPC_ADDR_MASK1_LO, {r1[3:0], 4'h0});
         wr(MPC_ADDR_MASK2_HI, r2[15:8]);
         wr(MPC_ADDR_MASK2_LO, {r2[3:0], 4'h0});
         rd(MPC_ADDR_MASK2_HI, r2[15:8]);
         check(block_pd, mask_exp(r1[15:8], {r1[3:0], 4'h0}));
         wr(MPC_ADDR_POWER, 8'h60);
         check(block_pd, mask_exp(r2[15:8], {r2[3:0], 4'h0}));
         wr(MPC_ADDR_POWER, 8'h40);
      end
      wr(MPC_ADDR_MASKED_PD, 8'h00);
      check(block_pd, 12'h000);
      wr(MPC_ADDR_BOOST, 8'h40);
      wr(MPC_ADDR_BIAS, 8'h08);
      check({10'h0, boost, bias}, 12'h003);
      rd(MPC_ADDR_BIAS, 8'h08);
      wr(MPC_ADDR_REQ_ONES, 8'hE0);
      check({9'h0, req_ones}, 12'h007);
      rd(MPC_ADDR_REQ_ONES, 8'hE0);
      wr(MPC_ADDR_CLK_FRAME, 8'h80);
      count_pulses(20);
      @(posedge clock_in);
      sysref_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      check({11'h0, frame_ref}, 12'h001);
      wr(MPC_ADDR_CLK_FRAME, 8'hC0);
      check({11'h0, frame_ref}, 12'h000);
      print_verdict();
   end
endmodule
bind mpc_master_page mpc_master_page_props #(.MASK_W(MASK_W)) i_mpc_master_page_props (.clock_in(clock_in),
   .rst_in(rst_in), .sen_n_in(sen_n_in), .sysref_in(sysref_in), .pdn_pin_in(pdn_pin_in), .sdout_out(sdout_out),
   .full_powerdown_out(full_powerdown_out), .block_powerdown_out(block_powerdown_out),
   .sample_enable_out(sample_enable_out), .frame_ref_out(frame_ref_out));
